// ### rtl/vxu_pkg.sv
// vxu_pkg: constants shared by the address translation unit
// assumes a 32-bit virtual address space and a 36-bit physical address
package vxu_pkg;
  localparam int VA_W = 32;
  localparam int PA_W = 36;
  localparam int SPACE_IDENTIFIER_W = 8;
  localparam int PPN_W = 19;
  localparam int FRAME_W = 24;
  localparam int MASK_W = 12;
  localparam int CATTR_W = 3;
  localparam int JOINT_ENTRIES = 48;
  localparam int FETCH_ENTRIES = 2;
  localparam int PAGE_SHIFT = 12;
  localparam int IDX_W = 6;
  // page mask codes: 4k and 16m only; the sizes between have no constant here
  localparam logic [11:0] MASK_4K = 12'h000;
  localparam logic [11:0] MASK_16M = 12'hfff;
  // coherency attribute encodings
  localparam logic [2:0] CA_NONCOHERENT = 3'h3;
  localparam logic [2:0] CA_UNCACHED = 3'h2;
  localparam logic [2:0] CA_EXCLUSIVE = 3'h4;
  localparam logic [2:0] CA_EXCL_WRITE = 3'h5;
  localparam logic [2:0] CA_UPDATE = 3'h6;
  // addressing mode codes from the status register
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h2;
  // segment top bits
  localparam logic [2:0] SEG_CACHED = 3'h4;
  localparam logic [2:0] SEG_UNCACHED = 3'h5;
  localparam logic [2:0] SEG_SUPER = 3'h6;
  localparam logic [2:0] SEG_KTOP = 3'h7;
  localparam logic [2:0] DIRECT_BASE_TOP = 3'h0;
endpackage : vxu_pkg

// ### rtl/vxu_translate.sv
// vxu_translate: joint and fetch translation buffers with segment decode
// assumes fetch and load/store stages on clk; software writes via wr_* ports
`timescale 1ns/1ps
module vxu_translate #(
  parameter int ENTRIES = vxu_pkg::JOINT_ENTRIES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic [7:0] cur_space_identifier,
  input wire logic [5:0] locked_count,
  input wire logic [11:0] page_size_mask,
  input wire logic wr_en,
  input wire logic wr_random,
  input wire logic [5:0] wr_index,
  input wire logic [18:0] wr_page_pair_number,
  input wire logic [7:0] wr_space_identifier,
  input wire logic [30:0] wr_even_page_half,
  input wire logic [30:0] wr_odd_page_half,
  input wire logic [5:0] rd_index,
  output logic [11:0] rd_mask,
  output logic [18:0] rd_page_pair_number,
  output logic [7:0] rd_space_identifier,
  output logic [30:0] rd_even_page_half,
  output logic [30:0] rd_odd_page_half,
  output logic [5:0] random_index,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [31:0] data_vaddr,
  output logic data_done,
  output logic [35:0] data_paddr,
  output logic [2:0] data_cache_attr,
  output logic load_xlate_miss,
  output logic store_xlate_miss,
  output logic data_write_protect,
  output logic data_addr_error,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_vaddr,
  output logic fetch_done,
  output logic fetch_stall,
  output logic [35:0] fetch_paddr,
  output logic [2:0] fetch_cache_attr,
  output logic fetch_xlate_miss,
  output logic fetch_addr_error
);
  // half layout: {frame[30:7], attr[6:4], dirty[3], valid[2], global[1], 0}
  // six-bit indices compare against ENTRIES, so 64 would wrap to zero
  if (ENTRIES < 2 || ENTRIES > 63) begin : g_entries_chk
    $error("vxu_translate: ENTRIES out of range");
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [11:0] e_mask [ENTRIES];
  logic [18:0] e_pair [ENTRIES];
  logic [7:0] e_sid [ENTRIES];
  logic [30:0] e_lo0 [ENTRIES];
  logic [30:0] e_lo1 [ENTRIES];
  logic [5:0] fill_index;

  // segment decode shared by both ports
  // returns {mapped, direct, uncached, error}
  function automatic logic [3:0] seg_decode(input logic [1:0] m,
                                            input logic [31:0] va);
    logic [2:0] top;
    top = va[31:29];
    seg_decode = 4'h1;
    case (m)
      vxu_pkg::MODE_USER: seg_decode = va[31] ? 4'h1 : 4'h8;
      vxu_pkg::MODE_SUPER:
        seg_decode = (!va[31] || top == vxu_pkg::SEG_SUPER) ? 4'h8 : 4'h1;
      vxu_pkg::MODE_KERNEL: begin
        if (top == vxu_pkg::SEG_CACHED)
          seg_decode = 4'h4;
        else if (top == vxu_pkg::SEG_UNCACHED)
          seg_decode = 4'h6;
        else
          seg_decode = 4'h8;
      end
      default: seg_decode = 4'h1;
    endcase
  endfunction : seg_decode

  // full joint lookup; {hit, valid, dirty, attr[2:0], frame[23:0], mask}
  function automatic logic [41:0] joint_lookup(input logic [31:0] va,
                                               input logic [7:0] sid);
    logic [30:0] half;
    logic odd;
    joint_lookup = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      // identifier match, global in both halves
      if (((va[31:13] & ~{7'h00, e_mask[i]}) ==
           (e_pair[i] & ~{7'h00, e_mask[i]})) &&
          ((e_lo0[i][1] && e_lo1[i][1]) || e_sid[i] == sid)) begin
        // odd select from bit above page offset
        odd = |({va[24:12]} & {e_mask[i], 1'b1} & ~{1'b0, e_mask[i]});
        half = odd ? e_lo1[i] : e_lo0[i];
        joint_lookup = {1'b1, half[2], half[3], half[6:4], half[30:7],
                        e_mask[i]};
      end
    end
  endfunction : joint_lookup

  // compose physical address from frame, mask and virtual offset
  function automatic logic [35:0] make_pa(input logic [23:0] frame,
                                          input logic [11:0] msk,
                                          input logic [31:0] va);
    logic [35:0] base;
    logic [35:0] offm;
    base = {frame, 12'h000};
    offm = {12'h000, msk, 12'hfff};
    make_pa = (base & ~offm) | ({4'h0, va} & offm);
  endfunction : make_pa

  // ---------------------------------------------------------------
  // random replacement
  // ---------------------------------------------------------------
  // counts down, wrapping above locked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      random_index <= 6'(ENTRIES - 1);
    // wrap one step early so a locked entry is never offered
    else if ({1'b0, random_index} <= {1'b0, locked_count} + 7'h01)
      random_index <= 6'(ENTRIES - 1);
    else
      random_index <= random_index - 6'h01;
  end

  // ---------------------------------------------------------------
  // software writes
  // ---------------------------------------------------------------
  assign fill_index = wr_random ? random_index : wr_index;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        e_mask[i] <= '0;
        e_pair[i] <= '0;
        e_sid[i] <= '0;
        e_lo0[i] <= '0;
        e_lo1[i] <= '0;
      end
    end else if (wr_en && fill_index < 6'(ENTRIES)) begin
      e_mask[fill_index] <= page_size_mask & vxu_pkg::MASK_16M;
      e_pair[fill_index] <= wr_page_pair_number;
      e_sid[fill_index] <= wr_space_identifier;
      e_lo0[fill_index] <= {wr_even_page_half[30:1], 1'b0};
      e_lo1[fill_index] <= {wr_odd_page_half[30:1], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_mask <= '0;
      rd_page_pair_number <= '0;
      rd_space_identifier <= '0;
      rd_even_page_half <= '0;
      rd_odd_page_half <= '0;
    end else if (rd_index < 6'(ENTRIES)) begin
      rd_mask <= e_mask[rd_index];
      rd_page_pair_number <= e_pair[rd_index];
      rd_space_identifier <= e_sid[rd_index];
      rd_even_page_half <= e_lo0[rd_index];
      rd_odd_page_half <= e_lo1[rd_index];
    end else begin
      rd_mask <= '0;
      rd_page_pair_number <= '0;
      rd_space_identifier <= '0;
      rd_even_page_half <= '0;
      rd_odd_page_half <= '0;
    end
  end

  // ---------------------------------------------------------------
  // data translation, one cycle
  // ---------------------------------------------------------------
  logic [3:0] d_seg;
  logic [41:0] d_look;
  assign d_seg = seg_decode(mode, data_vaddr);
  // always_comb so that entry writes also re-run the lookup
  always_comb d_look = joint_lookup(data_vaddr, cur_space_identifier);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_done <= 1'b0;
      data_paddr <= '0;
      data_cache_attr <= '0;
      load_xlate_miss <= 1'b0;
      store_xlate_miss <= 1'b0;
      data_write_protect <= 1'b0;
      data_addr_error <= 1'b0;
    end else begin
      data_done <= data_req;
      data_addr_error <= data_req && d_seg[0];
      // direct segments drop top three bits
      if (d_seg[2]) begin
        data_paddr <= {4'h0, vxu_pkg::DIRECT_BASE_TOP, data_vaddr[28:0]};
        data_cache_attr <= d_seg[1] ? vxu_pkg::CA_UNCACHED
                                    : vxu_pkg::CA_NONCOHERENT;
      end else begin
        data_paddr <= make_pa(d_look[35:12], d_look[11:0], data_vaddr);
        data_cache_attr <= d_look[38:36];
      end
      load_xlate_miss <= data_req && !data_write && d_seg[3] &&
                         !(d_look[41] && d_look[40]);
      store_xlate_miss <= data_req && data_write && d_seg[3] &&
                          !(d_look[41] && d_look[40]);
      data_write_protect <= data_req && data_write && d_seg[3] &&
                            d_look[41] && d_look[40] && !d_look[39];
    end
  end

  // ---------------------------------------------------------------
  // fetch buffer, 4k pages
  // ---------------------------------------------------------------
  // two entries of 4k pages
  logic [19:0] f_vpn [vxu_pkg::FETCH_ENTRIES];
  logic [23:0] f_frame [vxu_pkg::FETCH_ENTRIES];
  logic [2:0] f_attr [vxu_pkg::FETCH_ENTRIES];
  logic [7:0] f_sid [vxu_pkg::FETCH_ENTRIES];
  logic [vxu_pkg::FETCH_ENTRIES-1:0] f_valid;
  logic [vxu_pkg::FETCH_ENTRIES-1:0] f_hit;
  logic f_victim;
  logic f_any;
  logic [3:0] f_seg;
  logic [41:0] f_look;
  logic [35:0] f_pa_full;

  genvar g;
  generate
    for (g = 0; g < vxu_pkg::FETCH_ENTRIES; g++) begin : g_fhit
      assign f_hit[g] = f_valid[g] && f_vpn[g] == fetch_vaddr[31:12] &&
                        f_sid[g] == cur_space_identifier;
    end
  endgenerate
  assign f_any = |f_hit;
  assign f_seg = seg_decode(mode, fetch_vaddr);
  always_comb f_look = joint_lookup(fetch_vaddr, cur_space_identifier);
  assign f_pa_full = make_pa(f_look[35:12], f_look[11:0], fetch_vaddr);
  assign fetch_stall = fetch_req && f_seg[3] && !f_any &&
                       f_look[41] && f_look[40];

  // hardware refill; flushed on any joint write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_valid <= '0;
      f_victim <= 1'b0;
      for (int i = 0; i < vxu_pkg::FETCH_ENTRIES; i++) begin
        f_vpn[i] <= '0;
        f_frame[i] <= '0;
        f_attr[i] <= '0;
        f_sid[i] <= '0;
      end
    end else if (wr_en) begin
      f_valid <= '0;
    end else if (fetch_stall) begin
      f_valid[f_victim] <= 1'b1;
      f_vpn[f_victim] <= fetch_vaddr[31:12];
      f_frame[f_victim] <= f_pa_full[35:12];
      f_attr[f_victim] <= f_look[38:36];
      f_sid[f_victim] <= cur_space_identifier;
      f_victim <= ~f_victim;
    end
  end

  // fetch translates in parallel with data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_done <= 1'b0;
      fetch_paddr <= '0;
      fetch_cache_attr <= '0;
      fetch_xlate_miss <= 1'b0;
      fetch_addr_error <= 1'b0;
    end else begin
      fetch_done <= fetch_req && !fetch_stall;
      fetch_addr_error <= fetch_req && f_seg[0];
      fetch_xlate_miss <= fetch_req && f_seg[3] &&
                          !(f_look[41] && f_look[40]);
      if (f_seg[2]) begin
        fetch_paddr <= {4'h0, vxu_pkg::DIRECT_BASE_TOP, fetch_vaddr[28:0]};
        fetch_cache_attr <= f_seg[1] ? vxu_pkg::CA_UNCACHED
                                     : vxu_pkg::CA_NONCOHERENT;
      end else begin
        fetch_paddr <= {f_hit[1] ? f_frame[1] : f_frame[0],
                        fetch_vaddr[11:0]};
        fetch_cache_attr <= f_hit[1] ? f_attr[1] : f_attr[0];
      end
    end
  end
endmodule : vxu_translate

// ### testbench/vxu_chk.sv
// vxu_chk: port assertions for the translation unit
// assumes one clk domain and async active-low rst_n
`timescale 1ns/1ps
module vxu_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic [5:0] locked_count,
  input wire logic [5:0] random_index,
  input wire logic [30:0] rd_even_page_half,
  input wire logic [30:0] rd_odd_page_half,
  input wire logic data_req,
  input wire logic data_write,
  input wire logic [31:0] data_vaddr,
  input wire logic data_done,
  input wire logic [35:0] data_paddr,
  input wire logic [2:0] data_cache_attr,
  input wire logic load_xlate_miss,
  input wire logic store_xlate_miss,
  input wire logic data_write_protect,
  input wire logic data_addr_error,
  input wire logic fetch_req,
  input wire logic fetch_stall,
  input wire logic fetch_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  wire logic [2:0] top = data_vaddr[31:29];
  wire logic kreq = data_req && mode == 2'h0;
  wire logic miss = load_xlate_miss || store_xlate_miss;
  sequence s_stalled;
    fetch_req && fetch_stall;
  endsequence
  sequence s_refill;
    !fetch_stall ##1 fetch_done;
  endsequence
  chk_answer_next:
    assert property (data_req |=> data_done) else $error("no answer");
  chk_cached_direct:
    assert property (kreq && top == 3'h4 |=> data_cache_attr == 3'h3 &&
      data_paddr == {7'h0, $past(data_vaddr[28:0])}) else $error("cd");
  chk_uncached_direct:
    assert property (kreq && top == 3'h5 |=> data_cache_attr == 3'h2 &&
      data_paddr == {7'h0, $past(data_vaddr[28:0])}) else $error("ud");
  chk_user_bound:
    assert property (data_req && mode == 2'h2 && data_vaddr[31]
      |=> data_addr_error) else $error("user bound");
  chk_super_bound:
    assert property (data_req && mode == 2'h1 && top inside
      {3'h4, 3'h5, 3'h7} |=> data_addr_error) else $error("super bound");
  chk_random_wrap:
    assert property ({1'b0, random_index} <= {1'b0, locked_count} + 7'h01
      |=> random_index == 6'h2f) else $error("no wrap at locked bound");
  chk_random_free:
    assert property ($stable(locked_count) |-> random_index > locked_count)
      else $error("locked entry offered");
  chk_reserved_zero:
    assert property (!rd_even_page_half[0] && !rd_odd_page_half[0])
      else $error("reserved bit set");
  chk_miss_kind:
    assert property (miss |-> $past(data_req) && load_xlate_miss !=
      store_xlate_miss && store_xlate_miss == $past(data_write))
      else $error("miss kind");
  chk_protect_write:
    assert property (data_write_protect |-> $past(data_req && data_write))
      else $error("protect without write");
  chk_fetch_refill:
    assert property (s_stalled |=> s_refill) else $error("refill slow");
  chk_fetch_answer:
    assert property (fetch_req && !fetch_stall |=> fetch_done)
      else $error("no fetch answer");
endmodule : vxu_chk
bind vxu_translate vxu_chk u_chk (.*);

// ### testbench/vxu_fetch_stage.sv
// vxu_fetch_stage: fetch stage issuing one fetch per go pulse
// assumes go sampled at rising edge; request held while stalled
`timescale 1ns/1ps
module vxu_fetch_stage (
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] va,
  input wire logic fetch_stall,
  output logic fetch_req = 1'b0,
  output logic [31:0] fetch_vaddr = 32'h0,
  output logic [3:0] stalls = 4'h0
);
  logic taken = 1'b0;
  logic start = 1'b0;
  always @(posedge clk) begin
    taken <= fetch_req && !fetch_stall;
    start <= go && !fetch_req;
    if (go && !fetch_req)
      stalls <= 4'h0;
    else if (fetch_req && fetch_stall)
      stalls <= stalls + 4'h1;
  end
  // idle address is scrambled so stale values never look valid
  always @(negedge clk) begin
    if (start) begin
      fetch_req <= 1'b1;
      fetch_vaddr <= va;
    end else if (taken) begin
      fetch_req <= 1'b0;
      fetch_vaddr <= ~fetch_vaddr;
    end
  end
endmodule : vxu_fetch_stage

// ### testbench/tb_top.sv
// tb_top: directed tests of the translation unit
// assumes inputs driven at falling edge, fetch side from vxu_fetch_stage
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, wr_en = 0, wr_random = 0, go = 0;
  logic data_req = 0, data_write = 0;
  logic [1:0] mode = 0;
  logic [7:0] cur_space_identifier = 0, wr_space_identifier = 0;
  logic [5:0] locked_count = 0, wr_index = 0, rd_index = 0, ri;
  logic [11:0] page_size_mask = 0, rd_mask;
  logic [18:0] wr_page_pair_number = 0, rd_page_pair_number;
  logic [30:0] wr_even_page_half = 0, wr_odd_page_half = 0;
  logic [31:0] data_vaddr = 0, va = 0, fetch_vaddr;
  logic [7:0] rd_space_identifier;
  logic [30:0] rd_even_page_half, rd_odd_page_half;
  logic [5:0] random_index;
  logic data_done, load_xlate_miss, store_xlate_miss, fetch_req;
  logic data_write_protect, data_addr_error, fetch_done, fetch_stall;
  logic fetch_xlate_miss, fetch_addr_error;
  logic [35:0] data_paddr, fetch_paddr;
  logic [2:0] data_cache_attr, fetch_cache_attr;
  logic [3:0] stalls;
  int mismatches = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  vxu_translate DUT (.*);
  vxu_fetch_stage u_fetch (.*);
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [30:0] h(logic [23:0] f, logic [2:0] c,
    logic [2:0] dvg);
    return {f, c, dvg, 1'b0};
  endfunction : h
  function automatic logic [43:0] ok(logic [2:0] c, logic [35:0] p);
    return {5'h10, c, p};
  endfunction : ok
  function automatic logic [43:0] fl(logic [3:0] f);
    return {1'b1, f, 39'h0};
  endfunction : fl
  task automatic put(input logic [5:0] i, input logic [18:0] p,
    input logic [7:0] s, input logic [30:0] e, input logic [30:0] o);
    @(negedge clk);
    wr_en = 1;
    wr_index = i;
    wr_page_pair_number = p;
    wr_space_identifier = s;
    wr_even_page_half = e;
    wr_odd_page_half = o;
    ri = random_index;
    @(negedge clk);
    wr_en = 0;
  endtask : put
  task automatic rd(input logic [5:0] i);
    @(negedge clk);
    rd_index = i;
    @(negedge clk);
  endtask : rd
  // fault results hide address and attribute
  task automatic xl(input logic w, input logic [31:0] a,
    input logic [43:0] exp);
    logic f;
    @(negedge clk);
    data_req = 1;
    data_write = w;
    data_vaddr = a;
    @(negedge clk);
    data_req = 0;
    f = |{load_xlate_miss, store_xlate_miss, data_write_protect};
    f = f | data_addr_error;
    chk({data_done, load_xlate_miss, store_xlate_miss, data_write_protect,
      data_addr_error, f ? 39'h0 : {data_cache_attr, data_paddr}}, exp);
  endtask : xl
  // a data access runs beside every fetch
  task automatic fe(input logic [31:0] a, input logic [44:0] exp);
    va = a;
    go = 1;
    xl(0, 32'h00400abc, ok(3'h3, 36'h000100abc));
    go = 0;
    for (int n = 0; n < 8 && fetch_done !== 1'b1; n++)
      @(negedge clk);
    if (fetch_done !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
    chk({stalls, fetch_xlate_miss, fetch_addr_error, fetch_cache_attr,
      fetch_paddr}, exp);
  endtask : fe
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    chk(random_index, 6'h2f);
    rd(0);
    chk({rd_even_page_half, rd_odd_page_half}, 0);
    xl(0, 32'h80001234, ok(3'h3, 36'h000001234));
    xl(1, 32'ha0000010, ok(3'h2, 36'h000000010));
    xl(0, 32'he0000000, fl(4'h8));
    xl(1, 32'h00000000, fl(4'h4));
    mode = 3;
    xl(0, 32'h00000000, fl(4'h1));
    $display("test kernel done");
    put(5, 19'h00200, 8'h11, h(24'h100, 3'h3, 6), h(24'h200, 3'h2, 2));
    put(6, 19'h00300, 8'h22, h(24'h500, 3'h3, 4), h(24'h501, 3'h3, 4));
    put(7, 19'h00400, 8'h33, h(24'h300, 3'h5, 7), h(24'h301, 3'h6, 7));
    put(8, 19'h00500, 8'h33, h(24'h400, 3'h3, 7), h(24'h401, 3'h3, 6));
    page_size_mask = 12'h003;
    put(9, 19'h00800, 8'h22, h(24'h600, 3'h3, 2), h(24'h604, 3'h3, 2));
    page_size_mask = vxu_pkg::MASK_16M;
    put(10, 19'h20000, 8'h22, h(24'h1000, 3'h3, 2), h(24'h2000, 3'h4, 6));
    page_size_mask = 0;
    put(47, 19'h7abcd, 8'h5a, h(24'h7, 3'h3, 2), h(24'h8, 3'h3, 2));
    rd(47);
    chk({rd_page_pair_number, rd_space_identifier}, 27'h7abcd5a);
    chk({rd_even_page_half, rd_odd_page_half},
      {h(24'h7, 3'h3, 2), h(24'h8, 3'h3, 2)});
    rd(9);
    chk(rd_mask, 12'h003);
    mode = 2;
    cur_space_identifier = 8'h11;
    xl(0, 32'h00400abc, ok(3'h3, 36'h000100abc));
    xl(1, 32'h00401004, fl(4'h2));
    xl(0, 32'h00401008, ok(3'h2, 36'h000200008));
    cur_space_identifier = 8'h22;
    xl(0, 32'h00400000, fl(4'h8));
    xl(0, 32'h00800010, ok(3'h5, 36'h000300010));
    xl(1, 32'h00801020, ok(3'h6, 36'h000301020));
    xl(0, 32'h00a00000, fl(4'h8));
    xl(0, 32'h00600000, fl(4'h8));
    xl(1, 32'h00601000, fl(4'h4));
    xl(0, 32'h01007ff0, ok(3'h3, 36'h000607ff0));
    xl(0, 32'h01001230, ok(3'h3, 36'h000601230));
    xl(1, 32'h41234567, ok(3'h4, 36'h002234567));
    $display("test mapped done");
    xl(0, 32'h80000000, fl(4'h1));
    mode = 1;
    xl(0, 32'ha0000000, fl(4'h1));
    xl(0, 32'hc0000000, fl(4'h8));
    $display("test modes done");
    locked_count = 6'h2d;
    wr_random = 1;
    put(0, 19'h00555, 8'h22, h(24'h9, 3'h3, 2), h(24'ha, 3'h3, 2));
    wr_random = 0;
    chk(ri > 6'h2d, 1);
    rd(ri);
    chk(rd_page_pair_number, 19'h00555);
    rd(0);
    chk(rd_page_pair_number, 19'h0);
    $display("test random done");
    mode = 2;
    cur_space_identifier = 8'h11;
    fe(32'h00400010, {4'h1, 2'h0, 3'h3, 36'h000100010});
    fe(32'h00400ff0, {4'h0, 2'h0, 3'h3, 36'h000100ff0});
    $display("test fetch done");
    tally_and_finish;
  end
endmodule : tb_top
